// >>> include/fsbg_regs.svh
// register offsets, field positions and reset values of the flash security guard
`ifndef FSBG_REGS_SVH
`define FSBG_REGS_SVH
`define FSBG_OFF_SEC       12'h000
`define FSBG_OFF_CPC       12'h004
`define FSBG_OFF_CMD       12'h008
`define FSBG_OFF_STAT      12'h00C
`define FSBG_OFF_NVDATA    12'h010
`define FSBG_OFF_MAKER_ID  12'h014
`define FSBG_OFF_PART_ID   12'h018
`define FSBG_SEC_RESET     8'hFF
`define FSBG_BIT_LOCK      0
`define FSBG_BIT_INHIBIT   1
`define FSBG_BIT_P2_DIS    4
`define FSBG_BIT_P4_DIS    5
`define FSBG_BIT_HICLK     7
`define FSBG_CPC_APUPDATE  8'h01
`define FSBG_CMD_PROG_SEC  2'h1
`define FSBG_CMD_ERASE_ALL 2'h2
`define FSBG_CMD_DONE      2'h3
`define FSBG_MAKER_ID      8'hA5
`define FSBG_PART_ID       8'h5A
`define FSBG_RESP_OKAY     2'b00
`define FSBG_RESP_SLVERR   2'b10
`define FSBG_LOCKED_DATA   32'h0000_0000
`endif

// >>> include/fsbg_pkg.sv
// types of the flash security guard
package fsbg_pkg;
    typedef enum logic [1:0] {
        FSBG_RUN_APP    = 2'b00,
        FSBG_UPDATING   = 2'b01,
        FSBG_RUN_LOADER = 2'b11
    } fsbg_mode_t;
endpackage : fsbg_pkg

// >>> design/fsbg_guard.sv
// flash security byte, boot strap selection and code-read gating
`timescale 1ns/1ps
`default_nettype none
`include "fsbg_regs.svh"
module fsbg_guard (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // nonvolatile security byte storage
    input  wire logic [7:0]           nv_security_byte,
    output logic [7:0]                nv_write_data,
    output logic                      nv_write_en,
    // strap pins and programming-mode pin
    input  wire logic                 reboot_strap_a,
    input  wire logic                 reboot_strap_b,
    input  wire logic                 reboot_strap_c,
    input  wire logic                 prog_mode,
    // code-table read gating
    input  wire logic                 code_read_req,
    input  wire logic                 code_read_from_internal,
    input  wire logic                 code_read_target_internal,
    output logic                      code_read_allow_internal,
    output logic                      code_read_force_external,
    // external flash read path gating
    output logic                      flash_read_enable,
    // boot and clock outputs
    output fsbg_pkg::fsbg_mode_t      exec_mode,
    output logic                      boot_from_loader,
    output logic                      high_clock_select
);
    import fsbg_pkg::*;

    // pin synchronisers
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_nxt;
    always_comb begin
        pin_nxt = {prog_mode, reboot_strap_c, reboot_strap_b, reboot_strap_a};
    end
    always_ff @(posedge aclk) begin
        pin_s1_r <= pin_nxt;
        pin_s2_r <= pin_s1_r;
    end
    logic strap_a_s;
    logic strap_b_s;
    logic strap_c_s;
    logic prog_s;
    always_comb begin
        strap_a_s = pin_s2_r[0];
        strap_b_s = pin_s2_r[1];
        strap_c_s = pin_s2_r[2];
        prog_s    = pin_s2_r[3];
    end

    // security byte shadow, boot mode and control register
    logic [7:0]  sec_r;
    logic [7:0]  sec_nxt;
    logic        boot_ld_r;
    logic        boot_ld_nxt;
    logic        rst_d_r;
    logic [7:0]  cpc_r;
    logic [7:0]  cpc_nxt;
    fsbg_mode_t  mode_r;
    fsbg_mode_t  mode_nxt;
    logic [7:0]  nvw_data_r;
    logic [7:0]  nvw_data_nxt;
    logic        nvw_en_r;
    logic        nvw_en_nxt;

    // write channel state
    logic        aw_hold_r;
    logic        aw_hold_nxt;
    logic [11:0] aw_addr_r;
    logic [11:0] aw_addr_nxt;
    logic        w_hold_r;
    logic        w_hold_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic        w_strb0_r;
    logic        w_strb0_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        do_write;
    logic        wr_ok;

    // read channel state
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;

    logic locked;
    logic special_blocked;
    always_comb begin
        locked          = ~sec_r[`FSBG_BIT_LOCK];
        // reaching the byte or the ids while programming would defeat the lock
        special_blocked = prog_s | locked;
    end

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt  = w_hold_r;
        w_data_nxt  = w_data_r;
        w_strb0_nxt = w_strb0_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt  = 1'b1;
            w_data_nxt  = s_axi_wdata;
            w_strb0_nxt = s_axi_wstrb[0];
        end
        do_write = aw_hold_r && w_hold_r && !bvalid_r;
        wr_ok    = 1'b0;
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            unique case (aw_addr_r)
                `FSBG_OFF_CPC, `FSBG_OFF_CMD: wr_ok = 1'b1;
                default:                      wr_ok = 1'b0;
            endcase
            bresp_nxt = wr_ok ? `FSBG_RESP_OKAY : `FSBG_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        sec_nxt      = sec_r;
        cpc_nxt      = cpc_r;
        mode_nxt     = mode_r;
        boot_ld_nxt  = boot_ld_r;
        nvw_en_nxt   = 1'b0;
        nvw_data_nxt = nvw_data_r;
        if (!rst_d_r) begin
            // first cycle after reset release: shadow and straps
            sec_nxt     = nv_security_byte;
            boot_ld_nxt = 1'b0;
            if (!nv_security_byte[`FSBG_BIT_P2_DIS] && !strap_a_s && !strap_b_s) begin
                boot_ld_nxt = 1'b1;
            end
            if (!nv_security_byte[`FSBG_BIT_P4_DIS] && !strap_c_s) begin
                boot_ld_nxt = 1'b1;
            end
            mode_nxt = (boot_ld_nxt) ? FSBG_RUN_LOADER : FSBG_RUN_APP;
        end else if (do_write && wr_ok && w_strb0_r) begin
            if (aw_addr_r == `FSBG_OFF_CPC) begin
                cpc_nxt = w_data_r[7:0];
                if (w_data_r[7:0] == `FSBG_CPC_APUPDATE && mode_r == FSBG_RUN_APP) begin
                    mode_nxt = FSBG_UPDATING;
                end
            end else begin
                unique case (w_data_r[9:8])
                    `FSBG_CMD_PROG_SEC: begin
                        // a one can never come back through programming
                        sec_nxt      = sec_r & w_data_r[7:0];
                        nvw_en_nxt   = 1'b1;
                        nvw_data_nxt = sec_r & w_data_r[7:0];
                    end
                    `FSBG_CMD_ERASE_ALL: begin
                        sec_nxt      = `FSBG_SEC_RESET;
                        nvw_en_nxt   = 1'b1;
                        nvw_data_nxt = `FSBG_SEC_RESET;
                    end
                    `FSBG_CMD_DONE: begin
                        if (mode_r == FSBG_UPDATING) begin
                            // no reset and no bank switch after the update
                            mode_nxt = FSBG_RUN_APP;
                            cpc_nxt  = 8'h00;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `FSBG_RESP_OKAY;
            rdata_nxt  = `FSBG_LOCKED_DATA;
            unique case (s_axi_araddr)
                `FSBG_OFF_SEC:      rdata_nxt = special_blocked ? `FSBG_LOCKED_DATA
                                                                : {24'h00_0000, sec_r};
                `FSBG_OFF_MAKER_ID: rdata_nxt = special_blocked ? `FSBG_LOCKED_DATA
                                                                : {24'h00_0000, `FSBG_MAKER_ID};
                `FSBG_OFF_PART_ID:  rdata_nxt = special_blocked ? `FSBG_LOCKED_DATA
                                                                : {24'h00_0000, `FSBG_PART_ID};
                `FSBG_OFF_CPC:      rdata_nxt = {24'h00_0000, cpc_r};
                `FSBG_OFF_STAT:     rdata_nxt = {26'h000_0000, prog_s, locked,
                                                 boot_ld_r, high_clock_select, mode_r};
                `FSBG_OFF_CMD:      rdata_nxt = `FSBG_LOCKED_DATA;
                default:            rresp_nxt = `FSBG_RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_d_r    <= 1'b0;
            sec_r      <= `FSBG_SEC_RESET;
            cpc_r      <= 8'h00;
            mode_r     <= FSBG_RUN_APP;
            boot_ld_r  <= 1'b0;
            nvw_en_r   <= 1'b0;
            nvw_data_r <= `FSBG_SEC_RESET;
            aw_hold_r  <= 1'b0;
            aw_addr_r  <= 12'h000;
            w_hold_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_strb0_r  <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= `FSBG_RESP_OKAY;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            rresp_r    <= `FSBG_RESP_OKAY;
        end else begin
            rst_d_r    <= 1'b1;
            sec_r      <= sec_nxt;
            cpc_r      <= cpc_nxt;
            mode_r     <= mode_nxt;
            boot_ld_r  <= boot_ld_nxt;
            nvw_en_r   <= nvw_en_nxt;
            nvw_data_r <= nvw_data_nxt;
            aw_hold_r  <= aw_hold_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_hold_r   <= w_hold_nxt;
            w_data_r   <= w_data_nxt;
            w_strb0_r  <= w_strb0_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
        end
    end

    // code-table read gating
    always_comb begin
        if (code_read_from_internal) begin
            code_read_allow_internal = 1'b1;
        end else if (!sec_r[`FSBG_BIT_INHIBIT] || !rst_d_r) begin
            // the shadow holds ff until the first edge after reset, so stay shut
            code_read_allow_internal = 1'b0;
        end else begin
            code_read_allow_internal = 1'b1;
        end
        code_read_force_external = code_read_req && code_read_target_internal
                                   && !code_read_allow_internal;
        // lock only gates outside read paths; the core's own fetches are elsewhere
        flash_read_enable = !locked && !prog_s && rst_d_r;
    end

    always_comb begin
        s_axi_awready     = !aw_hold_r && rst_d_r;
        s_axi_wready      = !w_hold_r && rst_d_r;
        s_axi_bvalid      = bvalid_r;
        s_axi_bresp       = bresp_r;
        s_axi_arready     = !rvalid_r && rst_d_r;
        s_axi_rvalid      = rvalid_r;
        s_axi_rdata       = rdata_r;
        s_axi_rresp       = rresp_r;
        nv_write_en       = nvw_en_r;
        nv_write_data     = nvw_data_r;
        exec_mode         = mode_r;
        boot_from_loader  = boot_ld_r;
        high_clock_select = sec_r[`FSBG_BIT_HICLK];
    end
endmodule : fsbg_guard
`default_nettype wire

// >>> dv/fsbg_nv_model.sv
// nonvolatile store model that holds the security byte across resets
`timescale 1ns/1ps
`default_nettype none
module fsbg_nv_model #(
    parameter logic [7:0] INIT = 8'h4F  // bit7 low because the crystal runs under 24MHz
) (
    // clock
    input  wire logic       aclk,
    // commit from the guard
    input  wire logic       nv_write_en,
    input  wire logic [7:0] nv_write_data,
    // stored byte
    output logic [7:0]      nv_security_byte
);
    // no reset on purpose: the store must survive every reset of the guard
    // loader code is not held here; the writer keeps it from being all ones
    initial nv_security_byte = INIT;
    always @(posedge aclk) begin
        if (nv_write_en) nv_security_byte <= nv_write_data;
    end
endmodule : fsbg_nv_model
`default_nettype wire

// >>> dv/fsbg_guard_properties.sv
// concurrent checks on the ports of the flash security guard
`timescale 1ns/1ps
`default_nettype none
module fsbg_guard_props (
    // clock and reset
    input wire logic                 aclk,
    input wire logic                 aresetn,
    // register read channel
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    // store, straps and mode
    input wire logic [7:0]           nv_security_byte,
    input wire logic [7:0]           nv_write_data,
    input wire logic                 nv_write_en,
    input wire logic                 reboot_strap_a,
    input wire logic                 reboot_strap_b,
    input wire logic                 reboot_strap_c,
    input wire logic                 prog_mode,
    // code reads and outputs
    input wire logic                 code_read_req,
    input wire logic                 code_read_from_internal,
    input wire logic                 code_read_target_internal,
    input wire logic                 code_read_allow_internal,
    input wire logic                 code_read_force_external,
    input wire logic                 flash_read_enable,
    input wire fsbg_pkg::fsbg_mode_t exec_mode,
    input wire logic                 boot_from_loader
);
    import fsbg_pkg::*;
    logic up_r;
    logic wen_r;
    // the store lags the shadow by a commit, so skip the cycles around one
    wire logic ok = up_r && !nv_write_en && !wen_r;
    wire logic boot_exp = (!nv_security_byte[4] && !reboot_strap_a && !reboot_strap_b)
                          || (!nv_security_byte[5] && !reboot_strap_c);
    always_ff @(posedge aclk) begin
        up_r  <= aresetn;
        wen_r <= nv_write_en;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_commit_pulse: assert property (nv_write_en |=> !nv_write_en)
        else $error("store commit wider than one cycle");
    a_bits_only_clear: assert property (nv_write_en |-> nv_write_data == 8'hFF
        || (nv_write_data & ~nv_security_byte) == 8'h00) else $error("security bit set");
    a_lock_blocks: assert property (ok && !nv_security_byte[0] |-> !flash_read_enable)
        else $error("locked flash readable");
    a_prog_blocks: assert property ($past(prog_mode, 2) |-> !flash_read_enable)
        else $error("readable in programming mode");
    a_inhibit_ext: assert property (ok && code_read_req && !code_read_from_internal
        && code_read_target_internal && !nv_security_byte[1]
        |-> code_read_force_external && !code_read_allow_internal) else $error("inhibit open");
    a_internal_free: assert property (ok && code_read_req && code_read_from_internal
        && code_read_target_internal
        |-> code_read_allow_internal) else $error("internal code read refused");
    a_no_restrict: assert property (ok && code_read_req && code_read_target_internal
        && nv_security_byte[1:0] == 2'h3
        |-> code_read_allow_internal && !code_read_force_external) else $error("restricted");
    a_boot_pick: assert property (!up_r |=> boot_from_loader == boot_exp
        && exec_mode == (boot_exp ? FSBG_RUN_LOADER : FSBG_RUN_APP)) else $error("boot choice");
    a_update_back: assert property ($past(exec_mode) == FSBG_UPDATING
        && exec_mode != FSBG_UPDATING |-> exec_mode == FSBG_RUN_APP) else $error("left app");
endmodule : fsbg_guard_props
bind fsbg_guard fsbg_guard_props u_props (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .s_axi_arvalid             (s_axi_arvalid),
    .s_axi_arready             (s_axi_arready),
    .s_axi_rvalid              (s_axi_rvalid),
    .nv_security_byte          (nv_security_byte),
    .nv_write_data             (nv_write_data),
    .nv_write_en               (nv_write_en),
    .reboot_strap_a            (reboot_strap_a),
    .reboot_strap_b            (reboot_strap_b),
    .reboot_strap_c            (reboot_strap_c),
    .prog_mode                 (prog_mode),
    .code_read_req             (code_read_req),
    .code_read_from_internal   (code_read_from_internal),
    .code_read_target_internal (code_read_target_internal),
    .code_read_allow_internal  (code_read_allow_internal),
    .code_read_force_external  (code_read_force_external),
    .flash_read_enable         (flash_read_enable),
    .exec_mode                 (exec_mode),
    .boot_from_loader          (boot_from_loader)
);
`default_nettype wire

// >>> dv/tb_fsbg_guard.sv
// register-level bench for the flash security guard
`timescale 1ns/1ps
`default_nettype none
`include "fsbg_regs.svh"
module tb_fsbg_guard;
    import fsbg_pkg::*;
    logic        aclk, aresetn, prog_mode, nv_write_en, flash_read_enable;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  nv_security_byte, nv_write_data;
    logic        reboot_strap_a, reboot_strap_b, reboot_strap_c, code_read_req;
    logic        code_read_from_internal, code_read_target_internal;
    logic        code_read_allow_internal, code_read_force_external;
    logic        boot_from_loader, high_clock_select;
    fsbg_mode_t  exec_mode;
    int          bad_count, comparisons;
    fsbg_guard dut (.*);
    fsbg_nv_model nv (.*);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // address and data go out together; each is dropped on its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        // bready stays up between writes so it never falls and rises in one step
        chk("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask : rd
    // straps stay put through reset and after it, as a board with jumpers would
    task automatic rst(input logic a, input logic b, input logic c);
        aresetn <= 1'b0;
        reboot_strap_a <= a;
        reboot_strap_b <= b;
        reboot_strap_c <= c;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask : rst
    initial begin
        {aresetn, prog_mode, code_read_req, code_read_from_internal} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {reboot_strap_a, reboot_strap_b, reboot_strap_c} = 3'h7;
        code_read_target_internal = 1'b1;
        s_axi_wstrb = 4'hF;
        bad_count = 0;
        comparisons = 0;
        rst(1'b0, 1'b0, 1'b1);
        chk("boot", 32'h0000_0001, boot_from_loader);
        chk("mode", FSBG_RUN_LOADER, exec_mode);
        chk("hiclk", 32'h0000_0000, high_clock_select);
        rd(`FSBG_OFF_SEC, 32'h0000_004F, `FSBG_RESP_OKAY);
        wr(`FSBG_OFF_CMD, 32'h0000_01FF, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_SEC, 32'h0000_004F, `FSBG_RESP_OKAY);
        wr(`FSBG_OFF_CMD, 32'h0000_01FD, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_SEC, 32'h0000_004D, `FSBG_RESP_OKAY);
        code_read_req <= 1'b1;
        @(posedge aclk);
        chk("force_ext", 32'h0000_0001, code_read_force_external);
        chk("allow_int", 32'h0000_0000, code_read_allow_internal);
        code_read_from_internal <= 1'b1;
        @(posedge aclk);
        chk("allow_int", 32'h0000_0001, code_read_allow_internal);
        wr(`FSBG_OFF_CMD, 32'h0000_0200, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_SEC, 32'h0000_00FF, `FSBG_RESP_OKAY);
        chk("hiclk", 32'h0000_0001, high_clock_select);
        code_read_from_internal <= 1'b0;
        @(posedge aclk);
        chk("allow_int", 32'h0000_0001, code_read_allow_internal);
        code_read_req <= 1'b0;
        rst(1'b0, 1'b0, 1'b0);
        chk("boot", 32'h0000_0000, boot_from_loader);
        wr(`FSBG_OFF_CMD, 32'h0000_01DF, `FSBG_RESP_OKAY);
        rst(1'b1, 1'b1, 1'b0);
        chk("boot", 32'h0000_0001, boot_from_loader);
        rst(1'b0, 1'b0, 1'b1);
        chk("mode", FSBG_RUN_APP, exec_mode);
        wr(`FSBG_OFF_CPC, 32'h0000_0001, `FSBG_RESP_OKAY);
        chk("mode", FSBG_UPDATING, exec_mode);
        rd(`FSBG_OFF_CPC, 32'h0000_0001, `FSBG_RESP_OKAY);
        wr(`FSBG_OFF_CMD, 32'h0000_0300, `FSBG_RESP_OKAY);
        chk("mode", FSBG_RUN_APP, exec_mode);
        rd(`FSBG_OFF_CPC, 32'h0000_0000, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_MAKER_ID, 32'h0000_00A5, `FSBG_RESP_OKAY);
        prog_mode <= 1'b1;
        repeat (5) @(posedge aclk);
        rd(`FSBG_OFF_MAKER_ID, 32'h0000_0000, `FSBG_RESP_OKAY);
        chk("read_en", 32'h0000_0000, flash_read_enable);
        prog_mode <= 1'b0;
        repeat (5) @(posedge aclk);
        rd(12'h020, 32'h0000_0000, `FSBG_RESP_SLVERR);
        wr(`FSBG_OFF_SEC, 32'h0000_0000, `FSBG_RESP_SLVERR);
        wr(`FSBG_OFF_CMD, 32'h0000_01FE, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_PART_ID, 32'h0000_0000, `FSBG_RESP_OKAY);
        rd(`FSBG_OFF_STAT, 32'h0000_0014, `FSBG_RESP_OKAY);
        chk("read_en", 32'h0000_0000, flash_read_enable);
        tally_and_finish;
    end
    initial begin
        #2_000_000;
        bad_count++;
        tally_and_finish;
    end
endmodule : tb_fsbg_guard
`default_nettype wire
